// ===== src/ufc_regs.vh
// Register offsets, field positions, reset values and levels of the UART flow-control channel
`ifndef UFC_REGS_VH
`define UFC_REGS_VH

`define UFC_A_DATA      5'h00
`define UFC_A_IER       5'h01
`define UFC_A_IIR_FCR   5'h02
`define UFC_A_LCR       5'h03
`define UFC_A_MCR       5'h04
`define UFC_A_LSR       5'h05
`define UFC_A_MSR       5'h06
`define UFC_A_EFR       5'h08
`define UFC_A_TCR       5'h09
`define UFC_A_TLR       5'h0a
`define UFC_A_XON1      5'h0b
`define UFC_A_XON2      5'h0c
`define UFC_A_XOFF1     5'h0d
`define UFC_A_XOFF2     5'h0e
`define UFC_A_DLL       5'h0f
`define UFC_A_DLH       5'h10

`define UFC_EFR_AUTO_CTS  7
`define UFC_EFR_AUTO_RTS  6
`define UFC_EFR_SPECIAL   5
`define UFC_IER_XOFF      5
`define UFC_IER_MODEM     3
`define UFC_MCR_RTS       1
`define UFC_MCR_XON_ANY   5
`define UFC_FCR_ENABLE    0
`define UFC_FCR_RX_RST    1
`define UFC_FCR_TX_RST    2
`define UFC_IIR_XOFF      4

`define UFC_IIR_NONE      8'h01
`define UFC_LCR_RESET     8'h1d
`define UFC_DIV_RESET     8'h01
`define UFC_BYTE_ZERO     8'h00

`define UFC_RX_TRIG0      7'h08
`define UFC_RX_TRIG1      7'h10
`define UFC_RX_TRIG2      7'h38
`define UFC_RX_TRIG3      7'h3c
`define UFC_TX_TRIG0      7'h08
`define UFC_TX_TRIG1      7'h10
`define UFC_TX_TRIG2      7'h20
`define UFC_TX_TRIG3      7'h38
`define UFC_TRIG_ONE      7'h01
`define UFC_NO_FIFO_CAP   7'h01

`endif

// ===== src/ufc_mem.v
// Small synchronous memory with registered, write-first read port
`timescale 1ns/1ns
module ufc_mem #(
	parameter WIDTH = 8,
	parameter DEPTH = 64,
	parameter AW    = 6
) (
	input  wire             i_sys_clk,
	input  wire             i_clk_en,
	input  wire             i_we,
	input  wire [AW-1:0]    i_waddr,
	input  wire [WIDTH-1:0] i_wdata,
	input  wire [AW-1:0]    i_raddr,
	output reg  [WIDTH-1:0] o_rdata
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];

	always @(posedge i_sys_clk) begin
		if (i_clk_en) begin
			if (i_we)
				mem[i_waddr] <= i_wdata;
			// Bypass so a word written now is seen at once
			if (i_we && (i_waddr == i_raddr))
				o_rdata <= i_wdata;
			else
				o_rdata <= mem[i_raddr];
		end
	end
endmodule // ufc_mem

// ===== src/ufc_channel.v
// One UART channel: FIFOs, trigger levels, baud divider, hardware and software flow control
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`include "ufc_regs.vh"

module ufc_channel #(
	parameter DEPTH = 64,
	parameter AW    = 6
) (
	input  wire       i_sys_clk,
	input  wire       i_reset_n,
	input  wire       i_clk_en,
	input  wire [4:0] i_addr,
	input  wire [7:0] i_wr_data,
	input  wire       i_wr,
	input  wire       i_rd,
	output reg  [7:0] o_rd_data,
	input  wire       i_rx_valid,
	input  wire [7:0] i_rx_data,
	input  wire [2:0] i_rx_err,
	input  wire       i_tx_busy,
	output reg        o_tx_start,
	output reg  [7:0] o_tx_data,
	input  wire       i_cts_n,
	output reg        o_rts_n,
	output reg        o_baud_tick,
	output reg        o_int,
	output reg        o_receive_dma_request_n,
	output reg        o_transmit_dma_request_n
);
	localparam [2:0] SEQ_IDLE = 3'b001, SEQ_XOFF1 = 3'b010, SEQ_XON1 = 3'b100;
	localparam [2:0] TXF_IDLE = 3'b001, TXF_FIRST = 3'b010, TXF_SECOND = 3'b100;
	localparam [AW:0] CNT_ZERO = {(AW+1){1'b0}};
	localparam [AW:0] CNT_ONE  = {{AW{1'b0}}, 1'b1};
	localparam [AW:0] CNT_FULL = DEPTH[AW:0];
	// Trigger level from programmable nibble, else selectable field
	function [AW:0] trig_level;
		input       fifo_on;
		input [3:0] prog;
		input [1:0] sel;
		input       is_rx;
		begin
			if (!fifo_on)
				trig_level = `UFC_TRIG_ONE;
			else if (prog != 4'h0)
				trig_level = {1'b0, prog, 2'b00};
			else case (sel)
				2'b00:   trig_level = is_rx ? `UFC_RX_TRIG0 : `UFC_TX_TRIG0;
				2'b01:   trig_level = is_rx ? `UFC_RX_TRIG1 : `UFC_TX_TRIG1;
				2'b10:   trig_level = is_rx ? `UFC_RX_TRIG2 : `UFC_TX_TRIG2;
				default: trig_level = is_rx ? `UFC_RX_TRIG3 : `UFC_TX_TRIG3;
			endcase
		end
	endfunction
	reg  [7:0]    ier_q, fcr_q, lcr_q, mcr_q, efr_q, tcr_q, tlr_q;
	reg  [7:0]    xon1_q, xon2_q, xoff1_q, xoff2_q, dll_q, dlh_q;
	reg  [15:0]   baud_cnt_q;
	reg  [AW-1:0] rx_wp_q, rx_rp_q, tx_wp_q, tx_rp_q;
	reg  [AW:0]   rx_cnt_q, tx_cnt_q;
	reg           overrun_q, xoff_flag_q, sw_halt_q, rts_block_q;
	reg           xoff_sent_q, flow_kind_q, cts_d_q, delta_cts_q;
	reg  [2:0]    seq_q, seq_d, txf_q;
	reg           rx_store, rx_xoff, rx_xon, rx_special;
	wire [10:0]   rx_head;
	wire [7:0]    tx_head;
	wire          wr_data  = i_wr && (i_addr == `UFC_A_DATA);
	wire          rd_data  = i_rd && (i_addr == `UFC_A_DATA);
	wire          wr_fcr   = i_wr && (i_addr == `UFC_A_IIR_FCR);
	wire          rd_iir   = i_rd && (i_addr == `UFC_A_IIR_FCR);
	wire          rd_msr   = i_rd && (i_addr == `UFC_A_MSR);
	wire          fifo_on  = fcr_q[`UFC_FCR_ENABLE];
	wire [AW:0]   cap      = fifo_on ? CNT_FULL : `UFC_NO_FIFO_CAP;
	wire [AW:0]   halt_lvl = {1'b0, tcr_q[3:0], 2'b00};
	wire [AW:0]   res_lvl  = {1'b0, tcr_q[7:4], 2'b00};
	wire [AW:0]   rx_trig  = trig_level(fifo_on, tlr_q[7:4], fcr_q[7:6], 1'b1);
	wire [AW:0]   tx_trig  = trig_level(fifo_on, tlr_q[3:0], fcr_q[5:4], 1'b0);
	wire          auto_cts = efr_q[`UFC_EFR_AUTO_CTS];
	wire          auto_rts = efr_q[`UFC_EFR_AUTO_RTS];
	wire [1:0]    tx_mode  = efr_q[3:2];
	wire [1:0]    rx_mode  = efr_q[1:0];
	// Receive character classification
	always @* begin
		rx_store   = 1'b1;
		rx_xoff    = 1'b0;
		rx_xon     = 1'b0;
		rx_special = 1'b0;
		seq_d      = seq_q;
		case (rx_mode)
			2'b10, 2'b01: begin
				if (i_rx_data == (rx_mode[1] ? xoff1_q : xoff2_q)) begin
					rx_xoff  = 1'b1;
					rx_store = 1'b0;
				end else if (i_rx_data == (rx_mode[1] ? xon1_q : xon2_q)) begin
					rx_xon   = 1'b1;
					rx_store = 1'b0;
				end
			end
			2'b11: begin
				case (seq_q)
					SEQ_XOFF1: begin
						seq_d = SEQ_IDLE;
						if (i_rx_data == xoff2_q) begin
							rx_xoff  = 1'b1;
							rx_store = 1'b0;
						end
					end
					SEQ_XON1: begin
						seq_d = SEQ_IDLE;
						if (i_rx_data == xon2_q) begin
							rx_xon   = 1'b1;
							rx_store = 1'b0;
						end
					end
					default: begin
						if (i_rx_data == xoff1_q) begin
							seq_d    = SEQ_XOFF1;
							rx_store = 1'b0;
						end else if (i_rx_data == xon1_q) begin
							seq_d    = SEQ_XON1;
							rx_store = 1'b0;
						end
					end
				endcase
			end
			default: seq_d = SEQ_IDLE;
		endcase
		// Any character but a recognised Xoff resumes; first Xon consumed, a second one later stored
		if (sw_halt_q && mcr_q[`UFC_MCR_XON_ANY] && !rx_xoff) begin
			rx_xon = 1'b1;
			seq_d  = SEQ_IDLE;
		end
		if (efr_q[`UFC_EFR_SPECIAL] && (i_rx_data == xoff2_q) && !rx_xoff) begin
			rx_special = 1'b1;
			rx_store   = 1'b1;
		end
	end
	wire rx_push = i_rx_valid && rx_store && (rx_cnt_q < cap);
	wire rx_pop  = rd_data && (rx_cnt_q != CNT_ZERO);
	wire tx_push = wr_data && (tx_cnt_q < cap);
	wire can_go  = !i_tx_busy && !o_tx_start && (!auto_cts || !i_cts_n);
	wire flow_go = can_go && (txf_q != TXF_IDLE);
	wire tx_pop  = can_go && !flow_go && !sw_halt_q && (tx_cnt_q != CNT_ZERO);
	wire [AW-1:0] rx_rp_d = rx_rp_q + {{(AW-1){1'b0}}, rx_pop};
	wire [AW-1:0] tx_rp_d = tx_rp_q + {{(AW-1){1'b0}}, tx_pop};
	wire [7:0] flow_char = (txf_q == TXF_SECOND || tx_mode == 2'b01) ?
		(flow_kind_q ? xoff2_q : xon2_q) : (flow_kind_q ? xoff1_q : xon1_q);
	wire [7:0] out_char  = flow_go ? flow_char : tx_head;
	wire [7:0] len_mask  = 8'hff >> (2'd3 - lcr_q[1:0]);
	ufc_mem #(.WIDTH(11), .DEPTH(DEPTH), .AW(AW)) u_rx_mem (
		.i_sys_clk (i_sys_clk),
		.i_clk_en  (i_clk_en),
		.i_we      (rx_push),
		.i_waddr   (rx_wp_q),
		.i_wdata   ({i_rx_err, i_rx_data}),
		.i_raddr   (rx_rp_d),
		.o_rdata   (rx_head)
	);
	ufc_mem #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_tx_mem (
		.i_sys_clk (i_sys_clk),
		.i_clk_en  (i_clk_en),
		.i_we      (tx_push),
		.i_waddr   (tx_wp_q),
		.i_wdata   (i_wr_data),
		.i_raddr   (tx_rp_d),
		.o_rdata   (tx_head)
	);
	// Register writes and FIFO pointers
	always @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			ier_q    <= `UFC_BYTE_ZERO;
			fcr_q    <= `UFC_BYTE_ZERO;
			lcr_q    <= `UFC_LCR_RESET;
			mcr_q    <= `UFC_BYTE_ZERO;
			efr_q    <= `UFC_BYTE_ZERO;
			tcr_q    <= `UFC_BYTE_ZERO;
			tlr_q    <= `UFC_BYTE_ZERO;
			xon1_q   <= `UFC_BYTE_ZERO;
			xon2_q   <= `UFC_BYTE_ZERO;
			xoff1_q  <= `UFC_BYTE_ZERO;
			xoff2_q  <= `UFC_BYTE_ZERO;
			dll_q    <= `UFC_DIV_RESET;
			dlh_q    <= `UFC_BYTE_ZERO;
			rx_wp_q  <= {AW{1'b0}};
			rx_rp_q  <= {AW{1'b0}};
			tx_wp_q  <= {AW{1'b0}};
			tx_rp_q  <= {AW{1'b0}};
			rx_cnt_q <= CNT_ZERO;
			tx_cnt_q <= CNT_ZERO;
		end else if (i_clk_en) begin
			if (i_wr) begin
				case (i_addr)
					`UFC_A_IER:     ier_q   <= i_wr_data;
					`UFC_A_IIR_FCR: fcr_q   <= i_wr_data;
					`UFC_A_LCR:     lcr_q   <= i_wr_data;
					`UFC_A_MCR:     mcr_q   <= i_wr_data;
					`UFC_A_EFR:     efr_q   <= i_wr_data;
					`UFC_A_TCR:     tcr_q   <= i_wr_data;
					`UFC_A_TLR:     tlr_q   <= i_wr_data;
					`UFC_A_XON1:    xon1_q  <= i_wr_data;
					`UFC_A_XON2:    xon2_q  <= i_wr_data;
					`UFC_A_XOFF1:   xoff1_q <= i_wr_data;
					`UFC_A_XOFF2:   xoff2_q <= i_wr_data;
					`UFC_A_DLL:     dll_q   <= i_wr_data;
					`UFC_A_DLH:     dlh_q   <= i_wr_data;
					default: ;
				endcase
			end
			if (wr_fcr && i_wr_data[`UFC_FCR_RX_RST]) begin
				rx_wp_q  <= {AW{1'b0}};
				rx_rp_q  <= {AW{1'b0}};
				rx_cnt_q <= CNT_ZERO;
			end else begin
				if (rx_push)
					rx_wp_q <= rx_wp_q + {{(AW-1){1'b0}}, 1'b1};
				rx_rp_q  <= rx_rp_d;
				rx_cnt_q <= rx_cnt_q + (rx_push ? CNT_ONE : CNT_ZERO) - (rx_pop ? CNT_ONE : CNT_ZERO);
			end
			if (wr_fcr && i_wr_data[`UFC_FCR_TX_RST]) begin
				tx_wp_q  <= {AW{1'b0}};
				tx_rp_q  <= {AW{1'b0}};
				tx_cnt_q <= CNT_ZERO;
			end else begin
				if (tx_push)
					tx_wp_q <= tx_wp_q + {{(AW-1){1'b0}}, 1'b1};
				tx_rp_q  <= tx_rp_d;
				tx_cnt_q <= tx_cnt_q + (tx_push ? CNT_ONE : CNT_ZERO) - (tx_pop ? CNT_ONE : CNT_ZERO);
			end
		end
	end
	// Flow-control state, flags and transmitter launch
	always @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			seq_q       <= SEQ_IDLE;
			txf_q       <= TXF_IDLE;
			sw_halt_q   <= 1'b0;
			xoff_flag_q <= 1'b0;
			overrun_q   <= 1'b0;
			rts_block_q <= 1'b0;
			xoff_sent_q <= 1'b0;
			flow_kind_q <= 1'b0;
			cts_d_q     <= 1'b0;
			delta_cts_q <= 1'b0;
			o_tx_start  <= 1'b0;
			o_tx_data   <= `UFC_BYTE_ZERO;
		end else if (i_clk_en) begin
			if (i_rx_valid) begin
				seq_q <= seq_d;
				if (rx_xoff)
					sw_halt_q <= 1'b1;
				else if (rx_xon)
					sw_halt_q <= 1'b0;
			end
			// Set beats clear
			if (i_rx_valid && ier_q[`UFC_IER_XOFF] && (rx_xoff || rx_special))
				xoff_flag_q <= 1'b1;
			else if ((i_rx_valid && rx_xon) || rd_iir)
				xoff_flag_q <= 1'b0;
			if (i_rx_valid && rx_store && !(rx_cnt_q < cap))
				overrun_q <= 1'b1;
			else if (i_rd && (i_addr == `UFC_A_LSR))
				overrun_q <= 1'b0;
			if (rx_cnt_q >= halt_lvl)
				rts_block_q <= 1'b1;
			else if (rx_cnt_q <= res_lvl)
				rts_block_q <= 1'b0;
			cts_d_q <= i_cts_n;
			if ((cts_d_q != i_cts_n) && !auto_cts)
				delta_cts_q <= 1'b1;
			else if (rd_msr)
				delta_cts_q <= 1'b0;
			case (txf_q)
				TXF_FIRST: begin
					if (flow_go)
						txf_q <= (tx_mode == 2'b11) ? TXF_SECOND : TXF_IDLE;
				end
				TXF_SECOND: begin
					if (flow_go)
						txf_q <= TXF_IDLE;
				end
				default: begin
					if (tx_mode != 2'b00 && !xoff_sent_q && rx_cnt_q >= halt_lvl) begin
						txf_q       <= TXF_FIRST;
						flow_kind_q <= 1'b1;
						xoff_sent_q <= 1'b1;
					end else if (xoff_sent_q && rx_cnt_q <= res_lvl) begin
						txf_q       <= (tx_mode != 2'b00) ? TXF_FIRST : TXF_IDLE;
						flow_kind_q <= 1'b0;
						xoff_sent_q <= 1'b0;
					end
				end
			endcase
			o_tx_start <= flow_go || tx_pop;
			if (flow_go || tx_pop)
				o_tx_data <= out_char & len_mask;
		end
	end
	// Baud divider, pins and register read-back
	always @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			baud_cnt_q               <= 16'h0000;
			o_baud_tick              <= 1'b0;
			o_rts_n                  <= 1'b1;
			o_int                    <= 1'b0;
			o_rd_data                <= `UFC_BYTE_ZERO;
			o_receive_dma_request_n  <= 1'b1;
			o_transmit_dma_request_n <= 1'b0;
		end else if (i_clk_en) begin
			// Divisor zero is illegal and stops the ticks
			if ({dlh_q, dll_q} == 16'h0000 || baud_cnt_q >= {dlh_q, dll_q} - 16'h0001) begin
				baud_cnt_q  <= 16'h0000;
				o_baud_tick <= ({dlh_q, dll_q} != 16'h0000);
			end else begin
				baud_cnt_q  <= baud_cnt_q + 16'h0001;
				o_baud_tick <= 1'b0;
			end
			o_rts_n <= auto_rts ? rts_block_q : !mcr_q[`UFC_MCR_RTS];
			o_int   <= xoff_flag_q || (ier_q[`UFC_IER_MODEM] && delta_cts_q);
			o_receive_dma_request_n  <= !(rx_cnt_q >= rx_trig);
			o_transmit_dma_request_n <= !((cap - tx_cnt_q) >= tx_trig);
			if (i_rd) begin
				case (i_addr)
					`UFC_A_DATA:    o_rd_data <= rx_head[7:0];
					`UFC_A_IER:     o_rd_data <= ier_q;
					`UFC_A_IIR_FCR: o_rd_data <= xoff_flag_q ? (8'h01 << `UFC_IIR_XOFF) : `UFC_IIR_NONE;
					`UFC_A_LCR:     o_rd_data <= lcr_q;
					`UFC_A_MCR:     o_rd_data <= mcr_q;
					`UFC_A_LSR:     o_rd_data <= {1'b0, (tx_cnt_q == CNT_ZERO), (tx_cnt_q == CNT_ZERO),
						rx_head[10:8] & {3{rx_cnt_q != CNT_ZERO}}, overrun_q, (rx_cnt_q != CNT_ZERO)};
					`UFC_A_MSR:     o_rd_data <= {3'b000, !cts_d_q, 3'b000, delta_cts_q};
					`UFC_A_EFR:     o_rd_data <= efr_q;
					`UFC_A_TCR:     o_rd_data <= tcr_q;
					`UFC_A_TLR:     o_rd_data <= tlr_q;
					`UFC_A_XON1:    o_rd_data <= xon1_q;
					`UFC_A_XON2:    o_rd_data <= xon2_q;
					`UFC_A_XOFF1:   o_rd_data <= xoff1_q;
					`UFC_A_XOFF2:   o_rd_data <= xoff2_q;
					`UFC_A_DLL:     o_rd_data <= dll_q;
					`UFC_A_DLH:     o_rd_data <= dlh_q;
					default:        o_rd_data <= `UFC_BYTE_ZERO;
				endcase
			end
		end
	end
endmodule // ufc_channel

// ===== test/ufc_chk_props.sv
// Port-level checker for the UART flow-control channel
`timescale 1ns/1ns
module ufc_chk (
	input wire       i_sys_clk,
	input wire       i_reset_n,
	input wire       i_wr,
	input wire       i_rd,
	input wire       i_rx_valid,
	input wire       i_tx_busy,
	input wire       i_cts_n,
	input wire       o_tx_start,
	input wire [7:0] o_tx_data,
	input wire       o_rts_n,
	input wire       o_int,
	input wire       o_receive_dma_request_n,
	input wire       o_transmit_dma_request_n
);
	reg  [2:0] cts_age_q;
	reg        cts_last_q;
	wire [2:0] cts_age_d;
	// Cycles since the clear-to-send input last moved
	assign cts_age_d = (i_cts_n != cts_last_q) ? 3'h0 : ((cts_age_q == 3'h7) ? 3'h7 : cts_age_q + 3'h1);
	always @(posedge i_sys_clk) begin
		cts_last_q <= i_cts_n;
		cts_age_q  <= i_reset_n ? cts_age_d : 3'h7;
	end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	start_idle_a: assert property (o_tx_start |-> !$past(i_tx_busy))
		else $error("start while line busy");
	start_pulse_a: assert property (o_tx_start |=> !o_tx_start)
		else $error("start longer than one cycle");
	tx_hold_a: assert property (!o_tx_start |-> $stable(o_tx_data))
		else $error("tx data moved without start");
	int_rise_a: assert property ($rose(o_int) |-> $past(i_rx_valid, 2) || $past(i_wr) || $past(i_wr, 2)
		|| cts_age_q < 3'h4)
		else $error("interrupt without cause");
	int_fall_a: assert property ($fell(o_int) |-> $past(i_rd) || $past(i_rd, 2) || $past(i_rx_valid)
		|| $past(i_rx_valid, 2) || $past(i_wr) || $past(i_wr, 2))
		else $error("interrupt cleared without cause");
	rts_cause_a: assert property ($changed(o_rts_n) |-> $past(i_rx_valid, 3) || $past(i_rx_valid, 2)
		|| $past(i_rd, 3) || $past(i_rd, 2) || $past(i_wr, 3) || $past(i_wr, 2))
		else $error("rts moved without fill change");
	rxdma_fall_a: assert property ($fell(o_receive_dma_request_n) |-> $past(i_rx_valid) || $past(i_rx_valid, 2)
		|| $past(i_wr) || $past(i_wr, 2))
		else $error("rx request without push");
	txdma_rise_a: assert property ($rose(o_transmit_dma_request_n) |-> $past(i_wr) || $past(i_wr, 2))
		else $error("tx request dropped without write");
endmodule // ufc_chk

bind ufc_channel ufc_chk u_chk (
	.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_wr(i_wr), .i_rd(i_rd), .i_rx_valid(i_rx_valid),
	.i_tx_busy(i_tx_busy), .i_cts_n(i_cts_n), .o_tx_start(o_tx_start), .o_tx_data(o_tx_data),
	.o_rts_n(o_rts_n), .o_int(o_int), .o_receive_dma_request_n(o_receive_dma_request_n),
	.o_transmit_dma_request_n(o_transmit_dma_request_n)
);

// ===== test/ufc_remote.sv
// Remote serialiser model: busy while a character is on the line, logs what went out
`timescale 1ns/1ns
module ufc_remote #(
	parameter BITS = 8
) (
	input  wire       i_sys_clk,
	input  wire       i_tx_start,
	input  wire [7:0] i_tx_data,
	output reg        o_tx_busy,
	output reg  [7:0] o_count,
	output reg  [7:0] o_last
);
	reg [3:0] left_q;
	initial begin
		o_tx_busy = 1'b0;
		o_count   = 8'h00;
		o_last    = 8'h00;
		left_q    = 4'h0;
	end
	always @(posedge i_sys_clk) begin
		if (i_tx_start) begin
			o_tx_busy <= 1'b1;
			left_q    <= BITS[3:0];
			o_count   <= o_count + 8'h01;
			o_last    <= i_tx_data;
		end else if (left_q != 4'h0) begin
			left_q <= left_q - 4'h1;
		end else begin
			o_tx_busy <= 1'b0;
		end
	end
endmodule // ufc_remote

// ===== test/tb_top.sv
// Self-checking bench for the UART flow-control channel
`timescale 1ns/1ns
`include "ufc_regs.vh"
module tb_top;
	reg        clk;
	reg        rst_n;
	reg        clk_en;
	reg        cts_n;
	reg        bw;
	reg        br;
	reg        rxv;
	reg  [4:0] addr;
	reg  [7:0] wdat;
	reg  [7:0] rxd;
	reg  [2:0] rxe;
	wire [7:0] rdata;
	wire [7:0] txd;
	wire [7:0] cnt;
	wire [7:0] last;
	wire       busy, start, rts_n, baud, intr, rxdma_n, txdma_n;
	integer    err_count, checks_done;

	ufc_channel DUT (.i_sys_clk(clk), .i_reset_n(rst_n), .i_clk_en(clk_en), .i_addr(addr), .i_wr_data(wdat),
		.i_wr(bw), .i_rd(br), .o_rd_data(rdata), .i_rx_valid(rxv), .i_rx_data(rxd), .i_rx_err(rxe),
		.i_tx_busy(busy), .o_tx_start(start), .o_tx_data(txd), .i_cts_n(cts_n), .o_rts_n(rts_n),
		.o_baud_tick(baud), .o_int(intr), .o_receive_dma_request_n(rxdma_n),
		.o_transmit_dma_request_n(txdma_n));
	ufc_remote u_remote (.i_sys_clk(clk), .i_tx_start(start), .i_tx_data(txd), .o_tx_busy(busy),
		.o_count(cnt), .o_last(last));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task print_verdict; begin
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end endtask

	task chk(input string n, input [7:0] e, input [7:0] g); begin
		checks_done = checks_done + 1;
		if (g !== e) begin
			err_count = err_count + 1;
			$display("mismatch %0s expected %h seen %h", n, e, g);
		end
	end endtask

	task ticks(input integer n); begin
		repeat (n) @(posedge clk);
	end endtask

	task reset; begin
		rst_n <= 1'b0;
		cts_n <= 1'b0;
		ticks(10);
		rst_n <= 1'b1;
		ticks(1);
	end endtask

	task wreg(input [4:0] a, input [7:0] d); begin
		addr <= a;
		wdat <= d;
		bw   <= 1'b1;
		ticks(1);
		bw <= 1'b0;
		ticks(1);
	end endtask

	task rreg(input [4:0] a, output [7:0] v); begin
		addr <= a;
		br   <= 1'b1;
		ticks(1);
		br <= 1'b0;
		ticks(1);
		v = rdata;
	end endtask

	task rx(input [7:0] c); begin
		rxd <= c;
		rxv <= 1'b1;
		ticks(1);
		rxv <= 1'b0;
		ticks(1);
	end endtask

	task wait_tx(input [7:0] n);
		integer i;
		begin
		i = 0;
		while (cnt !== n && i < 200) begin
			ticks(1);
			i = i + 1;
		end
		if (cnt !== n) begin
			chk("tx_count", n, cnt);
			print_verdict;
		end
	end endtask

	task t_reset;
		reg [7:0] v;
		reg [7:0] n;
		begin
		reset;
		chk("rts_n", 8'h01, {7'h0, rts_n});
		chk("txdma_n", 8'h00, {7'h0, txdma_n});
		chk("rxdma_n", 8'h01, {7'h0, rxdma_n});
		rreg(`UFC_A_IIR_FCR, v);
		chk("iir", `UFC_IIR_NONE, v);
		rreg(`UFC_A_LCR, v);
		chk("lcr", `UFC_LCR_RESET, v);
		rx(8'h41);
		ticks(2);
		chk("rxdma_one", 8'h00, {7'h0, rxdma_n});
		wreg(`UFC_A_DLL, 8'h03);
		n = 8'h00;
		repeat (30) begin
			ticks(1);
			n = n + {7'h0, baud};
		end
		chk("baud_ticks", 8'h0a, n);
	end endtask

	task t_cts;
		reg [7:0] b;
		begin
		reset;
		cts_n <= 1'b1;
		wreg(`UFC_A_LCR, 8'h03);
		wreg(`UFC_A_IIR_FCR, 8'h01);
		wreg(`UFC_A_EFR, 8'h80);
		b = cnt;
		wreg(`UFC_A_DATA, 8'h5a);
		ticks(20);
		chk("cts_hold", b, cnt);
		cts_n <= 1'b0;
		wait_tx(b + 8'h01);
		chk("cts_char", 8'h5a, last);
		wreg(`UFC_A_DATA, 8'ha1);
		wreg(`UFC_A_DATA, 8'ha2);
		wait_tx(b + 8'h02);
		cts_n <= 1'b1;
		ticks(30);
		chk("cts_next", 8'ha1, last);
		cts_n <= 1'b0;
		wait_tx(b + 8'h03);
		chk("cts_resume", 8'ha2, last);
	end endtask

	task t_rts;
		reg [7:0] v;
		begin
		reset;
		wreg(`UFC_A_IIR_FCR, 8'h01);
		wreg(`UFC_A_TCR, 8'h12);
		wreg(`UFC_A_EFR, 8'h40);
		ticks(2);
		chk("rts_on", 8'h00, {7'h0, rts_n});
		rxe <= 3'h5;
		rx(8'h30);
		rxe <= 3'h0;
		repeat (6) rx(8'h30);
		ticks(2);
		chk("rts_below", 8'h00, {7'h0, rts_n});
		rx(8'h37);
		ticks(2);
		chk("rts_halt", 8'h01, {7'h0, rts_n});
		rx(8'h38);
		rreg(`UFC_A_LSR, v);
		chk("extra_ok", 8'h00, v & 8'h02);
		chk("rx_err", 8'h14, v & 8'h1c);
		rreg(`UFC_A_DATA, v);
		chk("rx_head", 8'h30, v);
		repeat (3) rreg(`UFC_A_DATA, v);
		ticks(2);
		chk("rts_still", 8'h01, {7'h0, rts_n});
		rreg(`UFC_A_DATA, v);
		ticks(2);
		chk("rts_resume", 8'h00, {7'h0, rts_n});
	end endtask

	task t_xoff(input [1:0] m);
		reg [7:0] b;
		begin
		reset;
		wreg(`UFC_A_LCR, 8'h03);
		wreg(`UFC_A_IER, 8'h20);
		wreg(`UFC_A_XON1, 8'h11);
		wreg(`UFC_A_XON2, 8'h91);
		wreg(`UFC_A_XOFF1, 8'h13);
		wreg(`UFC_A_XOFF2, 8'h93);
		wreg(`UFC_A_EFR, {6'h0, m});
		if (m[1])
			rx(8'h13);
		ticks(2);
		if (m == 2'h3)
			chk("half_pair", 8'h00, {7'h0, intr});
		if (m[0])
			rx(8'h93);
		ticks(2);
		chk("xoff_int", 8'h01, {7'h0, intr});
		b = cnt;
		wreg(`UFC_A_DATA, 8'h66);
		ticks(20);
		chk("xoff_halt", b, cnt);
		if (m[1])
			rx(8'h11);
		if (m[0])
			rx(8'h91);
		wait_tx(b + 8'h01);
		ticks(2);
		chk("xon_int", 8'h00, {7'h0, intr});
	end endtask

	task t_any;
		reg [7:0] b;
		reg [7:0] v;
		begin
		reset;
		wreg(`UFC_A_XON1, 8'h11);
		wreg(`UFC_A_XON2, 8'h91);
		wreg(`UFC_A_XOFF1, 8'h13);
		wreg(`UFC_A_XOFF2, 8'h93);
		wreg(`UFC_A_EFR, 8'h03);
		wreg(`UFC_A_MCR, 8'h20);
		rx(8'h13);
		rx(8'h93);
		b = cnt;
		wreg(`UFC_A_DATA, 8'h66);
		ticks(20);
		chk("any_halt", b, cnt);
		rx(8'h41);
		wait_tx(b + 8'h01);
		rreg(`UFC_A_DATA, v);
		chk("any_kept", 8'h41, v);
		rx(8'h13);
		rx(8'h93);
		rx(8'h11);
		rx(8'h91);
		wreg(`UFC_A_DATA, 8'h67);
		wait_tx(b + 8'h02);
		rreg(`UFC_A_DATA, v);
		chk("xon2_kept", 8'h91, v);
	end endtask

	task t_special;
		reg [7:0] b;
		reg [7:0] v;
		begin
		reset;
		wreg(`UFC_A_IER, 8'h20);
		wreg(`UFC_A_XOFF2, 8'h5a);
		wreg(`UFC_A_EFR, 8'h20);
		rx(8'h5a);
		ticks(2);
		chk("spec_int", 8'h01, {7'h0, intr});
		b = cnt;
		wreg(`UFC_A_DATA, 8'h66);
		wait_tx(b + 8'h01);
		rreg(`UFC_A_IIR_FCR, v);
		chk("spec_iir", 8'h10, v);
		ticks(2);
		chk("spec_clr", 8'h00, {7'h0, intr});
		rreg(`UFC_A_DATA, v);
		chk("spec_kept", 8'h5a, v);
	end endtask

	task t_txf(input [1:0] m);
		reg [7:0] b;
		reg [7:0] n;
		reg [7:0] v;
		begin
		reset;
		wreg(`UFC_A_LCR, 8'h02);
		wreg(`UFC_A_IIR_FCR, 8'h01);
		wreg(`UFC_A_TCR, 8'h01);
		wreg(`UFC_A_XON1, 8'hf1);
		wreg(`UFC_A_XON2, 8'hf2);
		wreg(`UFC_A_XOFF1, 8'hf3);
		wreg(`UFC_A_XOFF2, 8'hf4);
		wreg(`UFC_A_EFR, {4'h0, m, 2'h0});
		b = cnt;
		n = (m == 2'h0) ? 8'h00 : ((m == 2'h3) ? 8'h02 : 8'h01);
		repeat (4) rx(8'h20);
		ticks(30);
		wait_tx(b + n);
		chk("xoff_count", b + n, cnt);
		if (m != 2'h0)
			chk("xoff_char", (m == 2'h2) ? 8'h73 : 8'h74, last);
		repeat (4) rreg(`UFC_A_DATA, v);
		ticks(30);
		wait_tx(b + n + n);
		chk("xon_count", b + n + n, cnt);
		if (m != 2'h0)
			chk("xon_char", (m == 2'h2) ? 8'h71 : 8'h72, last);
	end endtask

	initial begin
		rst_n       = 1'b0;
		clk_en      = 1'b1;
		cts_n       = 1'b0;
		bw          = 1'b0;
		br          = 1'b0;
		rxv         = 1'b0;
		addr        = 5'h00;
		wdat        = 8'h00;
		rxd         = 8'h00;
		rxe         = 3'h0;
		err_count   = 0;
		checks_done = 0;
		t_reset;
		t_cts;
		t_rts;
		t_xoff(2'h2);
		t_xoff(2'h1);
		t_xoff(2'h3);
		t_any;
		t_special;
		t_txf(2'h0);
		t_txf(2'h1);
		t_txf(2'h2);
		t_txf(2'h3);
		print_verdict;
	end
endmodule // tb_top
